/* File: hdl/ltc_trim_control.sv */
// Purpose: self-trim sequencer and register file of a line interface device
// Assumes: single hclk domain; analog trim loops handshake by a done level
// Notes:   all state lives in one packed struct, registered once
// Operation
// - read-only 8-bit drive width code; pulse = (width - offtime - 4) ticks
// - writing one to bit 6 starts whole-system trim; reads one while running
// - bit 5 picks battery settle wait: 300 ms clear, 30 ms set
// - bits 4..0 of first register enable five steps; clear when done
// - bits 4 and 3 of second register enable the monitor ADC steps
// - bit 2 of second register starts audio DAC offset trim
// - bit 1 of second register starts audio ADC offset trim
// - bit 0 of second register starts longitudinal balance trim
// - ring mismatch result, 5-bit read/write, reset value 0x10
// - minimum off time equals (5-bit off-time code plus 4) ticks
`timescale 1ns/100ps

module ltc_trim_control #(
	parameter int unsigned SETTLE_LONG  = ltc_pkg::SETTLE_LONG_CYCLES,
	parameter int unsigned SETTLE_SHORT = ltc_pkg::SETTLE_SHORT_CYCLES
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic [7:0]  drive_width_code,
	output logic      [7:0]  min_off_time_code,
	output logic      [7:0]  converter_drive_ticks,
	output logic      [9:0]  trim_step_active,
	output logic             trim_settling,
	input  wire logic        trim_step_done,
	input  wire logic [4:0]  ring_result_in,
	output logic      [4:0]  ring_mismatch_result
);

	ltc_pkg::ltc_regs_type r_ff;
	ltc_pkg::ltc_regs_type nxt_r;

	// highest pending step runs first, so ring gain goes before tip gain
	function automatic logic [3:0] pick_step(
		input logic [ltc_pkg::STEP_COUNT-1:0] pend
	);
		logic [3:0] sel;
		sel = 4'h0;
		for (int i = 0; i < ltc_pkg::STEP_COUNT; i++) begin
			if (pend[i]) begin
				sel = 4'(i);
			end
		end
		return sel;
	endfunction : pick_step

	function automatic logic [31:0] read_reg(
		input ltc_pkg::ltc_regs_type s,
		input logic [7:0]            idx
	);
		logic [31:0] v;
		v = 32'h0000_0000;
		case (idx)
			ltc_pkg::IDX_DRIVE_WIDTH: v[7:0] = s.drive_width;
			ltc_pkg::IDX_OFF_TIME:    v[4:0] = s.off_time;
			ltc_pkg::IDX_TRIM_ONE: begin
				v[ltc_pkg::TRIM_SYSTEM_BIT]  = s.system_trim;
				v[ltc_pkg::TRIM_SPEEDUP_BIT] = s.speedup;
				v[4:0] = s.steps[4:0];
			end
			ltc_pkg::IDX_TRIM_TWO:    v[4:0] = s.steps[9:5];
			ltc_pkg::IDX_RING_RESULT: v[4:0] = s.ring_result;
			default:                  v = 32'h0000_0000;
		endcase
		return v;
	endfunction : read_reg

	// byte address to register word index; upper address bits are ignored
	function automatic logic [7:0] reg_index(
		input logic [31:0] addr
	);
		return addr[9:2];
	endfunction : reg_index

	// step enables carried by a write; zero bits leave running steps alone
	function automatic logic [ltc_pkg::STEP_COUNT-1:0] write_steps(
		input logic [7:0]  idx,
		input logic [31:0] data
	);
		logic [ltc_pkg::STEP_COUNT-1:0] m;
		m = '0;
		case (idx)
			ltc_pkg::IDX_TRIM_ONE: begin
				m[4:0] = data[ltc_pkg::STEP_FIELD_MSB:0];
			end
			ltc_pkg::IDX_TRIM_TWO: begin
				m[9:5] = data[ltc_pkg::STEP_FIELD_MSB:0];
			end
			default: m = '0;
		endcase
		return m;
	endfunction : write_steps

	// one-hot of a step index; an index past the last step gives no bit
	function automatic logic [ltc_pkg::STEP_COUNT-1:0] step_onehot(
		input logic [3:0] idx
	);
		logic [ltc_pkg::STEP_COUNT-1:0] m;
		m = '0;
		for (int i = 0; i < ltc_pkg::STEP_COUNT; i++) begin
			m[i] = (idx == 4'(i));
		end
		return m;
	endfunction : step_onehot

	// settle counter reload; the wait lasts the reload plus one cycle
	function automatic logic [ltc_pkg::SETTLE_CNT_W-1:0] settle_load(
		input logic fast
	);
		logic [ltc_pkg::SETTLE_CNT_W-1:0] n;
		n = ltc_pkg::SETTLE_CNT_W'(SETTLE_LONG - 1);
		if (fast) begin
			n = ltc_pkg::SETTLE_CNT_W'(SETTLE_SHORT - 1);
		end
		return n;
	endfunction : settle_load

	// pulse width in converter ticks; wraps if off time plus 4 exceeds the width
	function automatic logic [7:0] drive_ticks(
		input logic [7:0] width,
		input logic [4:0] off_code
	);
		logic [7:0] t;
		t = width - {3'b000, off_code};
		t = t - ltc_pkg::DRIVE_TICK_OFFSET;
		return t;
	endfunction : drive_ticks

	// whole-system trim is over once the sequencer finds no step left
	function automatic logic system_done(
		input ltc_pkg::ltc_regs_type s
	);
		return s.system_trim && s.state == ltc_pkg::LTC_RUN &&
			s.steps == '0;
	endfunction : system_done

	logic                    addr_phase;
	logic [7:0]              wr_idx;
	logic                    done_edge;
	logic [ltc_pkg::STEP_COUNT-1:0] set_mask;
	logic [ltc_pkg::STEP_COUNT-1:0] clr_mask;
	logic                    set_system;

	assign addr_phase = hsel & htrans[1] & hready;
	assign wr_idx     = r_ff.wr_idx;

	always_comb begin
		nxt_r      = r_ff;
		set_mask   = '0;
		clr_mask   = '0;
		set_system = 1'b0;
		done_edge  = r_ff.done_sync & ~r_ff.done_prev;

		// two-stage synchronisers for the analog loop handshake
		nxt_r.done_meta = trim_step_done;
		nxt_r.done_sync = r_ff.done_meta;
		nxt_r.done_prev = r_ff.done_sync;
		nxt_r.ring_meta = ring_result_in;
		nxt_r.ring_sync = r_ff.ring_meta;
		nxt_r.drive_width = drive_width_code;

		// address phase: latch write target, prepare read data
		nxt_r.wr_pend = addr_phase & hwrite;
		if (addr_phase) begin
			nxt_r.wr_idx = reg_index(haddr);
			if (!hwrite) begin
				nxt_r.hrdata = read_reg(r_ff, reg_index(haddr));
			end
		end

		// data phase: writes of one start work, zeros cannot abort a step
		if (r_ff.wr_pend) begin
			set_mask = write_steps(wr_idx, hwdata);
			case (wr_idx)
				ltc_pkg::IDX_OFF_TIME: nxt_r.off_time = hwdata[4:0];
				ltc_pkg::IDX_TRIM_ONE: begin
					set_system = hwdata[ltc_pkg::TRIM_SYSTEM_BIT];
					nxt_r.speedup = hwdata[ltc_pkg::TRIM_SPEEDUP_BIT];
				end
				ltc_pkg::IDX_RING_RESULT:
					nxt_r.ring_result = hwdata[4:0];
				default: ;
			endcase
		end

		// sequencer
		case (r_ff.state)
			ltc_pkg::LTC_IDLE: begin
				if (set_system && !r_ff.system_trim) begin
					nxt_r.state = ltc_pkg::LTC_SETTLE;
					// the speedup bit of the starting write itself counts
					nxt_r.settle_cnt = settle_load(nxt_r.speedup);
				end else if (|r_ff.steps) begin
					nxt_r.state = ltc_pkg::LTC_RUN;
				end
			end
			ltc_pkg::LTC_SETTLE: begin
				if (r_ff.settle_cnt == '0) begin
					nxt_r.state = ltc_pkg::LTC_RUN;
				end else begin
					nxt_r.settle_cnt = r_ff.settle_cnt - 1'b1;
				end
			end
			ltc_pkg::LTC_RUN: begin
				if (|r_ff.steps) begin
					nxt_r.cur_step = pick_step(r_ff.steps);
					nxt_r.state    = ltc_pkg::LTC_WAIT;
				end else begin
					nxt_r.state = ltc_pkg::LTC_IDLE;
				end
			end
			ltc_pkg::LTC_WAIT: begin
				if (done_edge) begin
					clr_mask = step_onehot(r_ff.cur_step);
					// the loop settles its result before raising done, so
					// the synchronised word is steady when it is taken
					if (r_ff.cur_step == 4'(ltc_pkg::RING_STEP)) begin
						nxt_r.ring_result = r_ff.ring_sync;
					end
					nxt_r.state = ltc_pkg::LTC_RUN;
				end
			end
			default: nxt_r.state = ltc_pkg::LTC_IDLE;
		endcase

		// system trim enables every step; the flag drops a cycle after the last one clears
		if (set_system) begin
			nxt_r.system_trim = 1'b1;
			set_mask = '1;
		end else if (system_done(r_ff)) begin
			nxt_r.system_trim = 1'b0;
		end

		// a new enable in the cycle of completion is kept
		nxt_r.steps = (r_ff.steps & ~clr_mask) | set_mask;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r_ff <= '{
				wr_pend:     1'b0,
				wr_idx:      8'h00,
				hrdata:      32'h0000_0000,
				system_trim: 1'b0,
				speedup:     1'b0,
				steps:       '0,
				ring_result: ltc_pkg::RING_RESULT_RESET,
				off_time:    ltc_pkg::OFF_TIME_RESET,
				drive_width: 8'h00,
				state:       ltc_pkg::LTC_IDLE,
				settle_cnt:  '0,
				cur_step:    4'h0,
				done_meta:   1'b0,
				done_sync:   1'b0,
				done_prev:   1'b0,
				ring_meta:   5'h00,
				ring_sync:   5'h00
			};
		end else begin
			r_ff <= nxt_r;
		end
	end

	// zero wait state slave: every access completes OKAY in its data phase
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = r_ff.hrdata;

	assign min_off_time_code    = {3'b000, r_ff.off_time};
	assign converter_drive_ticks = drive_ticks(r_ff.drive_width,
		r_ff.off_time);
	assign trim_settling = (r_ff.state == ltc_pkg::LTC_SETTLE);
	assign ring_mismatch_result = r_ff.ring_result;

	always_comb begin
		trim_step_active = 10'h000;
		if (r_ff.state == ltc_pkg::LTC_WAIT) begin
			trim_step_active = step_onehot(r_ff.cur_step);
		end
	end

endmodule : ltc_trim_control

/* File: hdl/ltc_pkg.sv */
// Purpose: shared constants and types for the line interface trim control
// Assumes: 40 MHz hclk, AHB-Lite register access, 32-bit data
// Notes:   register indexes are word indexes; byte address is index times 4
package ltc_pkg;

	// register word indexes
	localparam logic [7:0] IDX_DRIVE_WIDTH = 8'h5e;
	localparam logic [7:0] IDX_OFF_TIME    = 8'h5d;
	localparam logic [7:0] IDX_TRIM_ONE    = 8'h60;
	localparam logic [7:0] IDX_TRIM_TWO    = 8'h61;
	localparam logic [7:0] IDX_RING_RESULT = 8'h62;

	// field positions
	localparam int TRIM_SYSTEM_BIT = 6;
	localparam int TRIM_SPEEDUP_BIT = 5;
	localparam int STEP_FIELD_MSB  = 4;
	localparam int STEP_COUNT      = 10;
	localparam int RING_STEP       = 4;

	// values after reset
	localparam logic [4:0] RING_RESULT_RESET = 5'h10;
	localparam logic [4:0] OFF_TIME_RESET    = 5'h00;

	// pulse width relation offset in 61.035 ns ticks
	localparam logic [7:0] DRIVE_TICK_OFFSET = 8'h04;

	// battery settle times
	localparam int CLK_PERIOD_NS   = 25;
	localparam int SETTLE_LONG_MS  = 300;
	localparam int SETTLE_SHORT_MS = 30;
	localparam int SETTLE_LONG_CYCLES =
		SETTLE_LONG_MS * (1000000 / CLK_PERIOD_NS);
	localparam int SETTLE_SHORT_CYCLES =
		SETTLE_SHORT_MS * (1000000 / CLK_PERIOD_NS);
	localparam int SETTLE_CNT_W = 24;

	typedef enum logic [1:0] {
		LTC_IDLE,
		LTC_SETTLE,
		LTC_RUN,
		LTC_WAIT
	} ltc_state_type;

	typedef struct packed {
		logic                    wr_pend;
		logic [7:0]              wr_idx;
		logic [31:0]             hrdata;
		logic                    system_trim;
		logic                    speedup;
		logic [STEP_COUNT-1:0]   steps;
		logic [4:0]              ring_result;
		logic [4:0]              off_time;
		logic [7:0]              drive_width;
		ltc_state_type           state;
		logic [SETTLE_CNT_W-1:0] settle_cnt;
		logic [3:0]              cur_step;
		logic                    done_meta;
		logic                    done_sync;
		logic                    done_prev;
		logic [4:0]              ring_meta;
		logic [4:0]              ring_sync;
	} ltc_regs_type;

endpackage : ltc_pkg

/* File: verification/ltc_properties.sv */
// Purpose: port checks for the trim control block
// Assumes: bench shortens the short settle wait to 8 cycles
// Notes:   watches the bus response, off time, drive tick, step and settle outputs plus its drive width and step done inputs
`timescale 1ns/100ps
module ltc_props (
	input wire logic       hclk,
	input wire logic       hresetn,
	input wire logic       hreadyout,
	input wire logic       hresp,
	input wire logic [7:0] drive_width_code,
	input wire logic [7:0] min_off_time_code,
	input wire logic [7:0] converter_drive_ticks,
	input wire logic [9:0] trim_step_active,
	input wire logic       trim_settling,
	input wire logic       trim_step_done
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus stalled or errored");
	a_drive_ticks: assert property ($past(hresetn) |->
		converter_drive_ticks == 8'($past(drive_width_code)
		- min_off_time_code - 8'h04)) else $error("drive ticks wrong");
	a_off_upper: assert property (min_off_time_code[7:5] == 3'h0)
		else $error("off time code too wide");
	a_one_step: assert property ($onehot0(trim_step_active))
		else $error("several steps active");
	a_settle_quiet: assert property (trim_settling |->
		trim_step_active == 10'h000) else $error("step during settle");
	a_done_clears: assert property ($rose(trim_step_done) &&
		|trim_step_active |-> ##[1:5] trim_step_active == 10'h000)
		else $error("step did not finish");
	a_settle_min: assert property ($rose(trim_settling) |->
		trim_settling[*7]) else $error("settle too short");
	a_settle_max: assert property ($rose(trim_settling) |->
		##[7:12] !trim_settling) else $error("settle too long");
endmodule : ltc_props

/* File: verification/ltc_trim_control_bench.sv */
// Purpose: self-checking bench for the trim control block
// Assumes: zero-wait slave; settle counts cut to 40 and 8 cycles
// Notes:   reads are scored through a queue by a monitor process
`timescale 1ns/100ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
	err_count++; $display("MISMATCH %0t %h %h", $time, a, b); end end
module ltc_trim_control_bench;
	logic        hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0;
	logic        rd_ph = 1'b0, done = 1'b0, hreadyout, hresp;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r, e;
	logic [7:0]  dwc = 8'h00, ix;
	logic [4:0]  rin = 5'h00, rmr;
	logic [9:0]  act;
	logic [31:0] exp_q[$];
	int          err_count = 0, comparisons = 0, cyc = 0;
	ltc_trim_control #(.SETTLE_LONG(40), .SETTLE_SHORT(8)) uut (
		.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
		.hresp, .drive_width_code(dwc), .min_off_time_code(),
		.converter_drive_ticks(), .trim_step_active(act),
		.trim_settling(), .trim_step_done(done), .ring_result_in(rin),
		.ring_mismatch_result(rmr));
	always #12.5 hclk = ~hclk;
	task automatic end_sim;
		if (err_count == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_sim
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			end_sim;
		end
	end
	// the oldest noted read value is due whenever a read data phase ends
	always @(posedge hclk) begin
		if (rd_ph && hreadyout) begin
			e = exp_q.pop_front();
			`CHK(hrdata, e)
		end
	end
	task automatic xfer(input logic [7:0] idx, input logic wr,
			input logic [31:0] d, input logic [31:0] x);
		haddr <= {22'h0, idx, 2'h0};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		rd_ph <= !wr;
		if (!wr)
			exp_q.push_back(x);
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd_ph <= 1'b0;
	endtask : xfer
	// done stays high until the step drops; the gap lets the sync see low
	task automatic serve(input int k);
		while (act === 10'h000) @(negedge hclk);
		`CHK(act, 10'(1 << k))
		@(posedge hclk);
		done <= 1'b1;
		while (act !== 10'h000) @(negedge hclk);
		@(posedge hclk);
		done <= 1'b0;
		repeat (4) @(posedge hclk);
	endtask : serve
	initial begin
		r = $urandom(32'he3b3);
		r = $urandom;
		dwc <= r[15:8];
		rin <= r[20:16];
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		`CHK(rmr, 5'h10)
		xfer(ltc_pkg::IDX_RING_RESULT, 1'b0, 0, 32'h0000_0010);
		xfer(ltc_pkg::IDX_TRIM_ONE, 1'b0, 0, 32'h0000_0000);
		xfer(ltc_pkg::IDX_TRIM_TWO, 1'b0, 0, 32'h0000_0000);
		xfer(8'h3f, 1'b0, 0, 32'h0000_0000);
		xfer(ltc_pkg::IDX_DRIVE_WIDTH, 1'b1, ~r, 0);
		xfer(ltc_pkg::IDX_DRIVE_WIDTH, 1'b0, 0, {24'h0, dwc});
		xfer(ltc_pkg::IDX_OFF_TIME, 1'b1, r, 0);
		xfer(ltc_pkg::IDX_OFF_TIME, 1'b0, 0, {27'h0, r[4:0]});
		xfer(ltc_pkg::IDX_RING_RESULT, 1'b1, ~r, 0);
		xfer(ltc_pkg::IDX_RING_RESULT, 1'b0, 0, {27'h0, ~r[4:0]});
		for (int i = 0; i < 10; i++) begin
			ix = i < 5 ? ltc_pkg::IDX_TRIM_ONE : ltc_pkg::IDX_TRIM_TWO;
			xfer(ix, 1'b1, 32'(1 << (i % 5)), 0);
			xfer(ix, 1'b0, 0, 32'(1 << (i % 5)));
			serve(i);
			xfer(ix, 1'b0, 0, 32'h0000_0000);
		end
		xfer(ltc_pkg::IDX_RING_RESULT, 1'b0, 0, {27'h0, rin});
		`CHK(rmr, rin)
		xfer(ltc_pkg::IDX_TRIM_ONE, 1'b1, 32'h0000_0060, 0);
		xfer(ltc_pkg::IDX_TRIM_ONE, 1'b0, 0, 32'h0000_007f);
		xfer(ltc_pkg::IDX_TRIM_TWO, 1'b0, 0, 32'h0000_001f);
		for (int k = 9; k >= 0; k--)
			serve(k);
		xfer(ltc_pkg::IDX_TRIM_ONE, 1'b0, 0, 32'h0000_0020);
		xfer(ltc_pkg::IDX_TRIM_TWO, 1'b0, 0, 32'h0000_0000);
		end_sim;
	end
endmodule : ltc_trim_control_bench
bind ltc_trim_control ltc_props u_props (.hclk, .hresetn, .hreadyout,
	.hresp, .drive_width_code, .min_off_time_code, .converter_drive_ticks,
	.trim_step_active, .trim_settling, .trim_step_done);
